// >>> cgsi_regs.vh
// register offsets, field positions, reset values for the global status block
// assumes byte addresses on an axi4-lite bus, one register per 32-bit word
//
// Overview of operation
// - enabled flag shows true controller state, no irq
// - bus-off status; only entry raises irq
// - error-passive status never raises an irq
// - bit 7 is read-only OR of all sources but timer overrun
// - bus-off flag set only passive to off
// - timer overrun set on 0xffff to 0 wrap
// - overrun clears on handler entry or write-one
// - frame-buffer flag set on burst receive done
// - buffer flag clears only after configs rewritten
// - stuff flag set on six equal bits
// - crc flag set on crc mismatch
// - form flag set on delimiter/eof violation
// - ack flag set on missing dominant ack
// - write one clears flag, zero keeps it
// - enable bit 7 gates combined request
// - enable bit 6 admits bus-off source
// - bits 5 and 4 admit rx/tx completions
// - bits 3 and 2 admit object errors, buffer
// - enable bit 1 admits general error flags
// - enable bit 0 gates timer overrun request
`ifndef CGSI_REGS_VH
`define CGSI_REGS_VH

`define CGSI_IDX_STATUS 8'hd9
`define CGSI_IDX_FLAGS 8'hda
`define CGSI_IDX_ENABLE 8'hdb
`define CGSI_ADDR_STATUS 10'h364
`define CGSI_ADDR_FLAGS 10'h368
`define CGSI_ADDR_ENABLE 10'h36c
`define CGSI_RST_FLAGS 8'h00
`define CGSI_RST_ENABLE 8'h00

`define CGSI_ST_ENABLED 2
`define CGSI_ST_BUS_OFF 1
`define CGSI_ST_ERR_PASSIVE 0

`define CGSI_F_COMBINED 7
`define CGSI_F_BUS_OFF 6
`define CGSI_F_TIMER_OVR 5
`define CGSI_F_FRAME_BUF 4
`define CGSI_F_STUFF 3
`define CGSI_F_CRC 2
`define CGSI_F_FORM 1
`define CGSI_F_ACK 0

`define CGSI_E_COMBINED 7
`define CGSI_E_BUS_OFF 6
`define CGSI_E_RX 5
`define CGSI_E_TX 4
`define CGSI_E_OBJ_ERR 3
`define CGSI_E_FRAME_BUF 2
`define CGSI_E_GEN_ERR 1
`define CGSI_E_TIMER_OVR 0

`define CGSI_RESP_OKAY 2'b00
`define CGSI_RESP_SLVERR 2'b10

`endif

// >>> cgsi_sync2.v
// two-flop synchroniser for a bundle of levels from outside the clock domain
// assumes aclk and synchronous active-low aresetn
`timescale 1ns/1ps
`default_nettype none
module cgsi_sync2 #(
  parameter W = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule
`default_nettype wire

// >>> cgsi_top.v
// global status and interrupt flags of a can controller, axi4-lite slave
// assumes event pulses come from the protocol engine on aclk; the
// controller state levels come from another domain and are synchronised
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cgsi_regs.vh"
module cgsi_top (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire controller_enabled_in,
  input wire bus_off_in,
  input wire error_passive_in,
  input wire timer_wrap,
  input wire timer_handler_ack,
  input wire frame_buffer_done,
  input wire object_configs_rewritten,
  input wire stuff_error,
  input wire crc_error,
  input wire form_error,
  input wire ack_error,
  input wire object_rx_irq,
  input wire object_tx_irq,
  input wire object_err_irq,
  output wire controller_irq,
  output wire timer_overrun_irq
);
  // controller state levels cross into aclk
  wire [2:0] state_sync;
  cgsi_sync2 #(.W(3)) u_state_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({controller_enabled_in, bus_off_in, error_passive_in}),
    .sync_out(state_sync)
  );
  wire controller_enabled_flag = state_sync[2];
  wire bus_off_state = state_sync[1];
  wire error_passive_state = state_sync[0];

  reg bus_off_prev_q;
  reg passive_prev_q;
  reg bus_off_irq_flag_q;
  reg timer_overrun_flag_q;
  reg frame_buffer_done_flag_q;
  reg stuff_error_flag_q;
  reg crc_error_flag_q;
  reg form_error_flag_q;
  reg ack_error_flag_q;
  reg [7:0] enable_q;

  // write channel
  reg aw_held_q;
  reg w_held_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_q || aw_fire;
  wire w_have = w_held_q || w_fire;
  wire [31:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire wr_go = aw_have && w_have && !bvalid_q;
  wire wr_hit_flags = wr_addr[9:2] == `CGSI_IDX_FLAGS
    && wr_addr[31:10] == 22'h000000;
  wire wr_hit_enable = wr_addr[9:2] == `CGSI_IDX_ENABLE
    && wr_addr[31:10] == 22'h000000;
  wire wr_hit_status = wr_addr[9:2] == `CGSI_IDX_STATUS
    && wr_addr[31:10] == 22'h000000;
  wire wr_lane0 = wr_go && wr_strb[0];
  wire [7:0] clr = (wr_lane0 && wr_hit_flags) ? wr_data[7:0] : 8'h00;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `CGSI_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_hit_flags || wr_hit_enable || wr_hit_status) ?
          `CGSI_RESP_OKAY : `CGSI_RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_held_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  // enable register
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= `CGSI_RST_ENABLE;
    end else if (wr_lane0 && wr_hit_enable) begin
      enable_q <= wr_data[7:0];
    end
  end

  // sticky flags; a set in the same cycle as a clear wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_off_prev_q <= 1'b0;
      passive_prev_q <= 1'b0;
      bus_off_irq_flag_q <= 1'b0;
      timer_overrun_flag_q <= 1'b0;
      frame_buffer_done_flag_q <= 1'b0;
      stuff_error_flag_q <= 1'b0;
      crc_error_flag_q <= 1'b0;
      form_error_flag_q <= 1'b0;
      ack_error_flag_q <= 1'b0;
    end else begin
      bus_off_prev_q <= bus_off_state;
      passive_prev_q <= error_passive_state;
      // entry only, from error passive
      if (bus_off_state && !bus_off_prev_q && passive_prev_q) begin
        bus_off_irq_flag_q <= 1'b1;
      end else if (clr[`CGSI_F_BUS_OFF]) begin
        bus_off_irq_flag_q <= 1'b0;
      end
      if (timer_wrap) begin
        timer_overrun_flag_q <= 1'b1;
      end else if (clr[`CGSI_F_TIMER_OVR] || timer_handler_ack) begin
        timer_overrun_flag_q <= 1'b0;
      end
      if (frame_buffer_done) begin
        frame_buffer_done_flag_q <= 1'b1;
      end else if (clr[`CGSI_F_FRAME_BUF] && object_configs_rewritten) begin
        frame_buffer_done_flag_q <= 1'b0;
      end
      if (stuff_error) begin
        stuff_error_flag_q <= 1'b1;
      end else if (clr[`CGSI_F_STUFF]) begin
        stuff_error_flag_q <= 1'b0;
      end
      if (crc_error) begin
        crc_error_flag_q <= 1'b1;
      end else if (clr[`CGSI_F_CRC]) begin
        crc_error_flag_q <= 1'b0;
      end
      if (form_error) begin
        form_error_flag_q <= 1'b1;
      end else if (clr[`CGSI_F_FORM]) begin
        form_error_flag_q <= 1'b0;
      end
      if (ack_error) begin
        ack_error_flag_q <= 1'b1;
      end else if (clr[`CGSI_F_ACK]) begin
        ack_error_flag_q <= 1'b0;
      end
    end
  end

  wire gen_err_any = stuff_error_flag_q || crc_error_flag_q ||
    form_error_flag_q || ack_error_flag_q;
  // polled image of every source but timer overrun
  wire combined_irq_flag = bus_off_irq_flag_q || frame_buffer_done_flag_q ||
    gen_err_any || object_rx_irq || object_tx_irq || object_err_irq;
  wire src_bus_off = enable_q[`CGSI_E_BUS_OFF] && bus_off_irq_flag_q;
  wire src_rx = enable_q[`CGSI_E_RX] && object_rx_irq;
  wire src_tx = enable_q[`CGSI_E_TX] && object_tx_irq;
  wire src_oerr = enable_q[`CGSI_E_OBJ_ERR] && object_err_irq;
  wire src_fb = enable_q[`CGSI_E_FRAME_BUF] &&
    frame_buffer_done_flag_q;
  wire src_gerr = enable_q[`CGSI_E_GEN_ERR] && gen_err_any;

  reg controller_irq_q;
  reg timer_overrun_irq_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      controller_irq_q <= 1'b0;
      timer_overrun_irq_q <= 1'b0;
    end else begin
      controller_irq_q <= enable_q[`CGSI_E_COMBINED] && (src_bus_off ||
        src_rx || src_tx || src_oerr || src_fb || src_gerr);
      timer_overrun_irq_q <= enable_q[`CGSI_E_TIMER_OVR] &&
        timer_overrun_flag_q;
    end
  end
  assign controller_irq = controller_irq_q;
  assign timer_overrun_irq = timer_overrun_irq_q;

  // read channel
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  wire ar_fire = s_axi_arvalid && !rvalid_q;
  wire rd_low = s_axi_araddr[31:10] == 22'h000000;
  wire [7:0] rd_word = s_axi_araddr[9:2];
  // status carries levels only, no event logic
  wire [7:0] status_val = {5'h00, controller_enabled_flag, bus_off_state,
    error_passive_state};
  wire [7:0] flags_val = {combined_irq_flag, bus_off_irq_flag_q,
    timer_overrun_flag_q, frame_buffer_done_flag_q, stuff_error_flag_q,
    crc_error_flag_q, form_error_flag_q, ack_error_flag_q};

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `CGSI_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= `CGSI_RESP_OKAY;
      if (rd_low && rd_word == `CGSI_IDX_STATUS) begin
        rdata_q <= {24'h000000, status_val};
      end else if (rd_low && rd_word == `CGSI_IDX_FLAGS) begin
        rdata_q <= {24'h000000, flags_val};
      end else if (rd_low && rd_word == `CGSI_IDX_ENABLE) begin
        rdata_q <= {24'h000000, enable_q};
      end else begin
        rdata_q <= 32'h00000000;
        rresp_q <= `CGSI_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> cgsi_chk.sv
// concurrent checks on bus answers and the overrun request of cgsi_top
// assumes one clock aclk and a synchronous active-low aresetn
`timescale 1ns/1ps
`default_nettype none
module cgsi_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rready,
  input wire logic timer_wrap,
  input wire logic timer_handler_ack,
  input wire logic timer_overrun_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_rd_next: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer missing");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write answer dropped");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answering");
  chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 32'h370 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 0)
    else $error("unmapped read answer wrong");
  chk_rd_flags: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 32'h368 |=> s_axi_rresp == 2'b00 &&
    s_axi_rdata[31:8] == 0) else $error("flag read answer wrong");
  chk_ovr_clear: assert property (
    timer_handler_ack && !timer_wrap ##1 !timer_wrap |=> !timer_overrun_irq)
    else $error("overrun request not cleared");
endmodule
bind cgsi_top cgsi_chk cgsi_chk_inst (.*);
`default_nettype wire

// >>> cgsi_eng_model.sv
// protocol engine stand-in: registers event pulses and channel state
// assumes the bench changes ev, st and cfg right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cgsi_eng_model (
  input wire logic aclk,
  input wire logic [6:0] ev,
  input wire logic [2:0] st,
  input wire logic cfg,
  output logic timer_wrap,
  output logic timer_handler_ack,
  output logic frame_buffer_done,
  output logic stuff_error,
  output logic crc_error,
  output logic form_error,
  output logic ack_error,
  output logic controller_enabled_in,
  output logic bus_off_in,
  output logic error_passive_in,
  output logic object_configs_rewritten
);
  always @(posedge aclk) begin
    {timer_wrap, timer_handler_ack, frame_buffer_done, stuff_error,
      crc_error, form_error, ack_error} <= ev;
    {controller_enabled_in, bus_off_in, error_passive_in} <= st;
    object_configs_rewritten <= cfg;
  end
endmodule
`default_nettype wire

// >>> tb_cgsi_top.sv
// self-checking bench for cgsi_top through its axi4-lite port
// assumes cgsi_eng_model drives events and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
`include "cgsi_regs.vh"
module tb_cgsi_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, cfg;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_wrap;
  logic timer_handler_ack, frame_buffer_done, object_configs_rewritten;
  logic stuff_error, crc_error, form_error, ack_error, object_rx_irq;
  logic object_tx_irq, object_err_irq, controller_irq, timer_overrun_irq;
  logic controller_enabled_in, bus_off_in, error_passive_in;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot, st;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] ev;
  int n_mismatch = 0;
  int samples_checked = 0;
  localparam logic [31:0] fa = {22'h0, `CGSI_ADDR_FLAGS};
  localparam logic [31:0] ea = {22'h0, `CGSI_ADDR_ENABLE};
  localparam logic [31:0] sa = {22'h0, `CGSI_ADDR_STATUS};
  cgsi_top cgsi_top_inst (.*);
  cgsi_eng_model cgsi_eng_model_inst (.*);
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
    input logic [1:0] er = 2'b00);
    logic aw_t, w_t;
    aw_t = 0;
    w_t = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (s_axi_awready) aw_t = 1;
      if (s_axi_wready) w_t = 1;
      s_axi_awvalid <= !aw_t;
      s_axi_wvalid <= !w_t;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    ck(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e,
    input logic [1:0] er = 2'b00);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    ck(s_axi_rdata, {24'h0, e});
    ck(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic fire(input int i);
    @(posedge aclk);
    ev <= 7'h1 << i;
    @(posedge aclk);
    ev <= 7'h0;
  endtask
  task automatic irq(input logic [7:0] en, input logic [1:0] exp);
    wr(ea, en);
    repeat (2) @(posedge aclk);
    ck(32'({controller_irq, timer_overrun_irq}), 32'(exp));
  endtask
  task automatic state(input logic [2:0] s, input logic [7:0] es, ef);
    @(posedge aclk);
    st <= s;
    repeat (6) @(posedge aclk);
    rd(sa, es);
    rd(fa, ef);
  endtask
  initial begin
    aresetn = 0;
    {ev, st, cfg, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {object_rx_irq, object_tx_irq, object_err_irq, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(fa, `CGSI_RST_FLAGS);
    rd(ea, `CGSI_RST_ENABLE);
    rd(sa, 8'h00);
    rd(32'h370, 8'h00, 2'b10);
    wr(32'h370, 8'hff, 2'b10);
    wr(sa, 8'hff);
    rd(sa, 8'h00);
    wr(fa, 8'h80);
    rd(fa, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      fire(i);
      rd(fa, 8'h80 | (8'h1 << i));
      wr(fa, ~(8'h1 << i) & 8'h7f);
      rd(fa, 8'h80 | (8'h1 << i));
      wr(fa, 8'h1 << i);
      rd(fa, 8'h00);
    end
    $display("test error flags done");
    fire(6);
    rd(fa, 8'h20);
    fire(5);
    rd(fa, 8'h00);
    fire(6);
    wr(fa, 8'h20);
    rd(fa, 8'h00);
    fire(4);
    wr(fa, 8'h10);
    rd(fa, 8'h90);
    cfg <= 1;
    wr(fa, 8'h10);
    rd(fa, 8'h00);
    cfg <= 0;
    $display("test overrun and buffer done");
    fire(0);
    irq(8'h02, 2'b00);
    irq(8'h82, 2'b10);
    irq(8'h80, 2'b00);
    rd(ea, 8'h80);
    wr(fa, 8'h01);
    fire(4);
    irq(8'h84, 2'b10);
    cfg <= 1;
    wr(fa, 8'h10);
    cfg <= 0;
    for (int j = 0; j < 3; j++) begin
      {object_err_irq, object_tx_irq, object_rx_irq} <= 3'h1 << j;
      irq(8'h80 | (8'h20 >> j), 2'b10);
      rd(fa, 8'h80);
      irq(8'h80, 2'b00);
    end
    {object_err_irq, object_tx_irq, object_rx_irq} <= 3'h0;
    fire(6);
    irq(8'hfe, 2'b00);
    irq(8'h01, 2'b01);
    fire(5);
    repeat (3) @(posedge aclk);
    ck(32'(timer_overrun_irq), 32'h0);
    $display("test requests done");
    state(3'b100, 8'h04, 8'h00);
    state(3'b101, 8'h05, 8'h00);
    state(3'b110, 8'h06, 8'hc0);
    irq(8'hc0, 2'b10);
    irq(8'h80, 2'b00);
    wr(fa, 8'h40);
    state(3'b100, 8'h04, 8'h00);
    state(3'b110, 8'h06, 8'h00);
    $display("test channel state done");
    test_done;
  end
  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end
endmodule
`default_nettype wire
